// ---- logic/genset_defs.svh ----
// Functional notes
// (R01) Operator mode: sequences only on commands
// (R02) Commands come from panel, inputs, Modbus
// (R03) Running operator mode: regulate speed, voltage
// (R04) Start persists until running or attempts spent
// (R05) Stop after cool-down; extended stop
// (R06) Second stop aborts cool-down
// (R07) Generator breaker close: direct or synchronised
// (R08) Mains-failure application: no regulation after close
// (R09) Generator breaker open: ramp or immediate
// (R10) Grid breaker close: direct or synchronised
// (R11) Grid breaker opens immediately
// (R12) Manual speed outputs follow input
// (R13) Manual voltage outputs follow input
// (R14) Test entered by shortcut or input
// (R15) Test timer to 999.0 min, zero endless
// (R16) Operator mode during test stop: keep running
// (R17) Island: load test refused
// (R18) Simple test: run, breaker open
// (R19) Load test: sync, close, deliver set point
// (R20) Full test: transfer load and back
// (R21) Load/full need grid sync permission, default off
// (R22) Test end: configured return mode
// (R23) Lockout refuses all sequences
`ifndef GENSET_DEFS_SVH
`define GENSET_DEFS_SVH
`define CLK_HZ           40000000
`define TENTH_MIN_CYC    (`CLK_HZ * 6)
`define TIMER_MAX_TENTHS 16'd9990
`define COOL_CYC_DEF     32'd2400000000
`define EXT_STOP_CYC_DEF 32'd1200000000
`define ATTEMPTS_DEF     8'h03
`define CTRL_RST         16'h0001
`define TEST_RST         16'h0100
`define ADDR_CTRL        4'h0
`define ADDR_TEST        4'h1
`define ADDR_TIMER       4'h2
`define ADDR_STATUS      4'h3
`define ADDR_CMD         4'h4
`define CTRL_MODE_LO     0
`define CTRL_ISLAND      3
`define CTRL_MAINS_FAIL  4
`define CTRL_SYNC_PERM   5
`define TEST_TYPE_LO     0
`define TEST_RET_LO      2
`define TEST_SETP_LO     8
`define CMD_START        0
`define CMD_STOP         1
`define CMD_GEN_CLOSE    2
`define CMD_GEN_OPEN     3
`define CMD_GRID_CLOSE   4
`define CMD_GRID_OPEN    5
`define CMD_TEST         6
`define CMD_W            7
`endif

// ---- logic/genset_pkg.sv ----
package genset_pkg;
   typedef enum logic [2:0] {
      MODE_AUTO,
      MODE_OPERATOR,
      MODE_TEST,
      MODE_MANUAL,
      MODE_LOCKOUT
   } mode_type;
   typedef enum logic [1:0] {
      TEST_SIMPLE,
      TEST_LOAD,
      TEST_FULL
   } test_kind_type;
   typedef enum logic [1:0] {
      RET_NONE,
      RET_OPERATOR,
      RET_AUTO,
      RET_MANUAL
   } ret_type;
endpackage

// ---- logic/genset_cmd_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface genset_cmd_if;
   logic [6:0] cmd;
   modport src (output cmd);
   modport dst (input cmd);
endinterface
`default_nettype wire

// ---- logic/genset_cmd_merge.sv ----
`timescale 1ns/100ps
`default_nettype none
// Merges the three command sources into one set of one-cycle pulses
module genset_cmd_merge (
   input  wire logic       i_mclk,
   input  wire logic       i_reset,
   input  wire logic [6:0] i_panel,
   input  wire logic [6:0] i_dig,
   input  wire logic [6:0] i_modbus,
   genset_cmd_if.src       cmd_port
);
   logic [6:0] dig_s1_q;
   logic [6:0] dig_s2_q;
   logic [6:0] dig_old_q;
   logic [6:0] dig_rise;
   assign dig_rise = dig_s2_q & ~dig_old_q;
   // Panel and Modbus are same-clock pulses; inputs are pins, edge detected [R02]
   assign cmd_port.cmd = i_panel | i_modbus | dig_rise;
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         dig_s1_q  <= 7'h00;
         dig_s2_q  <= 7'h00;
         dig_old_q <= 7'h00;
      end else begin
         dig_s1_q  <= i_dig;
         dig_s2_q  <= dig_s1_q;
         dig_old_q <= dig_s2_q;
      end
   end
endmodule
`default_nettype wire

// ---- logic/genset_manual_trim.sv ----
`timescale 1ns/100ps
`default_nettype none
// Synchronises the four raise/lower pins and forwards them while held
module genset_manual_trim (
   input  wire logic       i_mclk,
   input  wire logic       i_reset,
   input  wire logic       i_enable,
   input  wire logic [3:0] i_pins,
   output logic      [3:0] o_pulse,
   output logic            o_spd_manual,
   output logic            o_volt_manual
);
   logic [3:0] s1_q;
   logic [3:0] s2_q;
   logic [3:0] held;
   assign held = i_enable ? s2_q : 4'h0;
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         s1_q          <= 4'h0;
         s2_q          <= 4'h0;
         o_pulse       <= 4'h0;
         o_spd_manual  <= 1'b0;
         o_volt_manual <= 1'b0;
      end else begin
         s1_q          <= i_pins;
         s2_q          <= s1_q;
         o_pulse       <= held;               // [R12] [R13]
         o_spd_manual  <= |held[1:0];         // [R12]
         o_volt_manual <= |held[3:2];         // [R13]
      end
   end
endmodule
`default_nettype wire

// ---- logic/genset_sequencer.sv ----
// Strobed register access and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "genset_defs.svh"
module genset_sequencer
   import genset_pkg::*;
#(
   parameter logic [31:0] COOL_CYC     = `COOL_CYC_DEF,
   parameter logic [31:0] EXT_STOP_CYC = `EXT_STOP_CYC_DEF,
   parameter logic [31:0] TENTH_CYC    = `TENTH_MIN_CYC
) (
   // Clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_reset,
   // Register port
   input  wire logic [3:0]  i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [15:0] o_rdata,
   // Command sources
   input  wire logic [6:0]  i_panel_cmd,
   input  wire logic [6:0]  i_dig_cmd,
   input  wire logic [3:0]  i_trim_pins,
   // Plant feedback (pins)
   input  wire logic        i_running,
   input  wire logic        i_gen_closed,
   input  wire logic        i_grid_closed,
   input  wire logic        i_synced,
   input  wire logic        i_at_open_point,
   input  wire logic        i_attempts_done,
   // Plant control
   output logic             o_start_seq,
   output logic             o_stop_seq,
   output logic             o_gen_close,
   output logic             o_gen_open,
   output logic             o_grid_close,
   output logic             o_grid_open,
   output logic             o_sync_active,
   output logic             o_ramp_down,
   output logic             o_regulate,
   output logic             o_load_setp_en,
   output logic      [6:0]  o_load_setp,
   output logic      [3:0]  o_trim,
   output logic      [2:0]  o_mode
);
   typedef enum logic [3:0] {
      S_IDLE, S_START, S_RUN, S_COOL, S_EXTSTOP,
      S_SYNC_GEN, S_RAMP, S_SYNC_GRID, S_TEST_RUN, S_TEST_BACK
   } seq_type;

   seq_type      st_q, st_d;
   mode_type     mode_q;
   logic [15:0]  ctrl_q, test_q, timer_q;
   logic [31:0]  cnt_q;
   logic [31:0]  tick_q;
   logic [15:0]  tenths_q;
   logic [6:0]   cmd_w;
   logic [15:0]  rdata_d;
   logic         run_s1_q, run_q, gc_s1_q, gc_q, mc_s1_q, mc_q;
   logic         sy_s1_q, sy_q, op_s1_q, op_q, at_s1_q, at_q;
   logic         no_reg_q, mb_target_q, test_done;
   logic         spd_man, volt_man;
   logic [3:0]   trim_w;
   logic         lockout, operator_m, test_m, island, mains_fail, perm;
   test_kind_type tkind;
   ret_type      tret;
   logic         test_ok;
   logic [15:0]  timer_w;

   genset_cmd_if cmd_bus ();

   genset_cmd_merge u_merge (
      .i_mclk   (i_mclk),
      .i_reset  (i_reset),
      .i_panel  (i_panel_cmd),
      .i_dig    (i_dig_cmd),
      .i_modbus (cmd_w),
      .cmd_port (cmd_bus.src)
   );

   genset_manual_trim u_trim (
      .i_mclk        (i_mclk),
      .i_reset       (i_reset),
      .i_enable      (operator_m && run_q),
      .i_pins        (i_trim_pins),
      .o_pulse       (trim_w),
      .o_spd_manual  (spd_man),
      .o_volt_manual (volt_man)
   );

   function automatic logic [15:0] clamp_timer(input logic [15:0] v);
      clamp_timer = (v > `TIMER_MAX_TENTHS) ? `TIMER_MAX_TENTHS : v;
   endfunction

   assign lockout    = (mode_q == MODE_LOCKOUT);
   assign operator_m = (mode_q == MODE_OPERATOR);
   assign test_m     = (mode_q == MODE_TEST);
   assign island     = ctrl_q[`CTRL_ISLAND];
   assign mains_fail = ctrl_q[`CTRL_MAINS_FAIL];
   assign perm       = ctrl_q[`CTRL_SYNC_PERM];
   assign tkind      = test_kind_type'(test_q[`TEST_TYPE_LO +: 2]);
   assign tret       = ret_type'(test_q[`TEST_RET_LO +: 2]);
   // Load test needs grid permission and no island; full test needs permission
   assign test_ok    = (tkind == TEST_SIMPLE) ||                     // [R17] [R21]
                       (tkind == TEST_LOAD && perm && !island) ||
                       (tkind == TEST_FULL && perm);
   // Zero timer means endless test
   assign test_done  = (timer_q != 16'h0000) && (tenths_q >= timer_q); // [R15]
   assign timer_w    = clamp_timer(i_wdata);                          // [R15]
   assign cmd_w      = (i_wr && i_addr == `ADDR_CMD) ? i_wdata[`CMD_W-1:0] : 7'h00;

   // Register read mux
   always_comb begin
      rdata_d = 16'h0000;
      unique case (i_addr)
         `ADDR_CTRL:   rdata_d = ctrl_q;
         `ADDR_TEST:   rdata_d = test_q;
         `ADDR_TIMER:  rdata_d = timer_q;
         `ADDR_STATUS: rdata_d = {8'h00, st_q, 1'b0, mode_q};
         default:      rdata_d = 16'h0000;
      endcase
   end

   // Sequence engine: only commands move it out of idle in operator mode
   always_comb begin
      st_d = st_q;
      if (lockout) begin
         st_d = S_IDLE;                                           // [R23]
      end else begin
         unique case (st_q)
            S_IDLE: begin
               if (cmd_bus.cmd[`CMD_START] && operator_m)         // [R01]
                  st_d = S_START;
               else if (cmd_bus.cmd[`CMD_TEST] && test_ok)        // [R14]
                  st_d = S_START;
            end
            S_START: begin
               if (run_q)                                         // [R04]
                  st_d = test_m ? ((tkind == TEST_SIMPLE) ? S_TEST_RUN : S_SYNC_GEN) : S_RUN;
               else if (at_q)
                  st_d = S_IDLE;
            end
            S_RUN: begin
               if (cmd_bus.cmd[`CMD_STOP])
                  st_d = S_COOL;                                  // [R05]
               else if (cmd_bus.cmd[`CMD_GEN_CLOSE] && mc_q && !gc_q)
                  st_d = S_SYNC_GEN;                              // [R07]
               else if (cmd_bus.cmd[`CMD_GEN_OPEN] && gc_q && mc_q && !island)
                  st_d = S_RAMP;                                  // [R09]
               else if (cmd_bus.cmd[`CMD_GRID_CLOSE] && gc_q && !mc_q)
                  st_d = S_SYNC_GRID;                             // [R10]
            end
            S_SYNC_GEN:  if (gc_q) st_d = test_m ? S_TEST_RUN : S_RUN;
            S_SYNC_GRID: if (mc_q) st_d = test_m ? S_TEST_BACK : S_RUN;
            S_RAMP:      if (!gc_q) st_d = test_m ? S_COOL : S_RUN;
            S_TEST_RUN: begin
               if (test_done)                                     // [R18] [R19]
                  st_d = (tkind == TEST_FULL) ? S_SYNC_GRID : (gc_q ? S_RAMP : S_COOL);
            end
            S_TEST_BACK: st_d = S_RAMP;                           // [R20]
            S_COOL: begin
               if (operator_m && test_q[15])
                  st_d = S_RUN;                                   // [R16]
               else if (cmd_bus.cmd[`CMD_STOP] || cnt_q >= COOL_CYC)
                  st_d = S_EXTSTOP;                               // [R06]
            end
            S_EXTSTOP: begin
               if (!run_q && cnt_q >= EXT_STOP_CYC)
                  st_d = S_IDLE;                                  // [R05]
            end
            default: st_d = S_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         {run_s1_q, run_q, gc_s1_q, gc_q, mc_s1_q, mc_q} <= 6'h00;
         {sy_s1_q, sy_q, op_s1_q, op_q, at_s1_q, at_q} <= 6'h00;
      end else begin
         {run_s1_q, gc_s1_q, mc_s1_q} <= {i_running, i_gen_closed, i_grid_closed};
         {run_q, gc_q, mc_q}          <= {run_s1_q, gc_s1_q, mc_s1_q};
         {sy_s1_q, op_s1_q, at_s1_q}  <= {i_synced, i_at_open_point, i_attempts_done};
         {sy_q, op_q, at_q}           <= {sy_s1_q, op_s1_q, at_s1_q};
      end
   end

   // Registers; bit 15 of the test register marks a test-origin stop
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         ctrl_q  <= `CTRL_RST;  // Operator mode, permission off [R21]
         test_q  <= `TEST_RST;
         timer_q <= 16'h0000;
      end else begin
         if (i_wr && i_addr == `ADDR_CTRL)
            ctrl_q <= i_wdata;
         if (i_wr && i_addr == `ADDR_TEST)
            test_q <= {test_q[15], i_wdata[14:0]};
         else if (st_q == S_TEST_RUN)
            test_q[15] <= 1'b1;
         else if (st_q == S_IDLE || st_q == S_RUN)
            test_q[15] <= 1'b0;
         if (i_wr && i_addr == `ADDR_TIMER)
            timer_q <= timer_w;
         if (cmd_bus.cmd[`CMD_TEST] && test_ok && !lockout)
            ctrl_q[`CTRL_MODE_LO +: 3] <= MODE_TEST;              // [R14]
         else if (test_m && st_q != S_IDLE && st_d == S_IDLE && tret != RET_NONE)
            ctrl_q[`CTRL_MODE_LO +: 3] <= (tret == RET_OPERATOR) ? MODE_OPERATOR :
                                          (tret == RET_AUTO) ? MODE_AUTO : MODE_MANUAL; // [R22]
      end
   end

   assign mode_q = mode_type'(ctrl_q[`CTRL_MODE_LO +: 3]);

   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         st_q     <= S_IDLE;
         cnt_q    <= 32'h0;
         tick_q   <= 32'h0;
         tenths_q <= 16'h0;
         no_reg_q <= 1'b0;
         mb_target_q <= 1'b0;
         o_rdata  <= 16'h0000;
      end else begin
         st_q    <= st_d;
         cnt_q   <= (st_d != st_q) ? 32'h0 : cnt_q + 32'h1;
         o_rdata <= i_rd ? rdata_d : 16'h0000;
         if (st_q != S_TEST_RUN) begin
            tick_q   <= 32'h0;
            tenths_q <= 16'h0;
         end else if (tick_q >= TENTH_CYC - 32'h1) begin
            tick_q   <= 32'h0;
            tenths_q <= tenths_q + 16'h1;
         end else begin
            tick_q <= tick_q + 32'h1;
         end
         if (st_q == S_START)
            no_reg_q <= 1'b0;
         else if (cmd_bus.cmd[`CMD_GEN_CLOSE] && mains_fail)
            no_reg_q <= 1'b1;                                     // [R08]
         mb_target_q <= (st_q == S_TEST_RUN) && (tkind == TEST_FULL) && gc_q;
      end
   end

   // Plant outputs, registered
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         o_start_seq <= 1'b0; o_stop_seq <= 1'b0;
         o_gen_close <= 1'b0; o_gen_open <= 1'b0;
         o_grid_close <= 1'b0; o_grid_open <= 1'b0;
         o_sync_active <= 1'b0; o_ramp_down <= 1'b0;
         o_regulate <= 1'b0; o_load_setp_en <= 1'b0;
         o_load_setp <= 7'h00; o_trim <= 4'h0; o_mode <= 3'h0;
      end else begin
         o_start_seq   <= (st_q == S_START);                      // [R04]
         o_stop_seq    <= (st_q == S_EXTSTOP) || lockout;         // [R05] [R23]
         o_gen_close   <= !lockout && ((st_q == S_SYNC_GEN && sy_q) ||
                          (st_q == S_RUN && cmd_bus.cmd[`CMD_GEN_CLOSE] && !mc_q)); // [R07]
         o_gen_open    <= !lockout && ((st_q == S_RAMP && op_q) ||
                          (st_q == S_RUN && cmd_bus.cmd[`CMD_GEN_OPEN] && (!mc_q || island))); // [R09]
         // A stopped set may still close the grid breaker on command
         o_grid_close  <= !lockout && ((st_q == S_SYNC_GRID && sy_q) ||
                          ((st_q == S_RUN || (st_q == S_IDLE && operator_m)) &&
                           cmd_bus.cmd[`CMD_GRID_CLOSE] && !gc_q)); // [R10]
         o_grid_open   <= !lockout && ((cmd_bus.cmd[`CMD_GRID_OPEN] && operator_m) || mb_target_q); // [R11] [R20]
         o_sync_active <= (st_q == S_SYNC_GEN) || (st_q == S_SYNC_GRID);
         o_ramp_down   <= (st_q == S_RAMP);                       // [R09]
         o_regulate    <= run_q && !no_reg_q && !spd_man && !volt_man &&
                          (st_q != S_IDLE) && (st_q != S_EXTSTOP); // [R03] [R08]
         o_load_setp_en <= (st_q == S_TEST_RUN) && (tkind == TEST_LOAD) && gc_q; // [R19]
         o_load_setp   <= test_q[`TEST_SETP_LO +: 7];
         o_trim        <= trim_w;                                 // [R12] [R13]
         o_mode        <= mode_q;
      end
   end
endmodule
`default_nettype wire

// ---- testbench/genset_sequencer_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
module genset_sequencer_asserts
   import genset_pkg::*;
(
   input wire logic        i_mclk,
   input wire logic        i_reset,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [6:0]  i_panel_cmd,
   input wire logic [6:0]  i_dig_cmd,
   input wire logic [3:0]  i_trim_pins,
   input wire logic        i_gen_closed,
   input wire logic        i_grid_closed,
   input wire logic [15:0] o_rdata,
   input wire logic        o_start_seq,
   input wire logic        o_gen_close,
   input wire logic        o_grid_close,
   input wire logic        o_grid_open,
   input wire logic        o_sync_active,
   input wire logic        o_regulate,
   input wire logic [3:0]  o_trim,
   input wire logic [2:0]  o_mode
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_reset);
   logic [3:0] quiet_q;
   // Cycles since any command source moved; saturates so it never wraps back to quiet
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset)
         quiet_q <= 4'h0;
      else if (i_wr || (i_panel_cmd | i_dig_cmd) != 7'h00)
         quiet_q <= 4'h0;
      else if (quiet_q != 4'hF)
         quiet_q <= quiet_q + 4'h1;
   end
   sequence s_cmd(int b);
      i_panel_cmd[b] && o_mode == MODE_OPERATOR;
   endsequence
   property p_rdata_idle;
      !i_rd |=> o_rdata == 16'h0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
   property p_quiet_start;
      o_mode == MODE_OPERATOR && quiet_q > 4'h8 |-> !$rose(o_start_seq);
   endproperty
   a_quiet_start: assert property (p_quiet_start) else $error("start without command");
   property p_lockout;
      (o_mode == MODE_LOCKOUT) [*3] |-> !o_start_seq && !o_gen_close && !o_grid_close;
   endproperty
   a_lockout: assert property (p_lockout) else $error("sequence in lockout");
   property p_grid_open;
      s_cmd(5) |-> ##[1:3] o_grid_open;
   endproperty
   a_grid_open: assert property (p_grid_open) else $error("grid open late");
   property p_gen_close;
      s_cmd(2) |-> ##[1:3] (i_grid_closed ? o_sync_active : o_gen_close);
   endproperty
   a_gen_close: assert property (p_gen_close) else $error("generator close path wrong");
   property p_grid_close;
      s_cmd(4) |-> ##[1:3] (i_gen_closed ? o_sync_active : o_grid_close);
   endproperty
   a_grid_close: assert property (p_grid_close) else $error("grid close path wrong");
   property p_trim_off;
      (i_trim_pins == 4'h0) [*6] |-> o_trim == 4'h0;
   endproperty
   a_trim_off: assert property (p_trim_off) else $error("trim output outlives input");
   property p_trim_reg;
      o_trim != 4'h0 |-> !o_regulate;
   endproperty
   a_trim_reg: assert property (p_trim_reg) else $error("regulation during trim");
endmodule
bind genset_sequencer genset_sequencer_asserts seq_chk (.i_mclk, .i_reset, .i_wr, .i_rd, .i_panel_cmd,
   .i_dig_cmd, .i_trim_pins, .i_gen_closed, .i_grid_closed, .o_rdata, .o_start_seq, .o_gen_close,
   .o_grid_close, .o_grid_open, .o_sync_active, .o_regulate, .o_trim, .o_mode);
`default_nettype wire

// ---- testbench/genset_plant.sv ----
`timescale 1ns/100ps
`default_nettype none
// Engine, breakers and regulators; i_dly sets how slowly all but the breakers and the fixed attempt flag answer
module genset_plant (
   // Clock, reset and pace
   input  wire logic       i_mclk,
   input  wire logic       i_reset,
   input  wire logic [3:0] i_dly,
   // Commands from the controller
   input  wire logic       i_start_seq,
   input  wire logic       i_stop_seq,
   input  wire logic       i_gen_close,
   input  wire logic       i_gen_open,
   input  wire logic       i_grid_close,
   input  wire logic       i_grid_open,
   input  wire logic       i_sync_active,
   input  wire logic       i_ramp_down,
   // Feedback
   output logic            o_running,
   output logic            o_gen_closed,
   output logic            o_grid_closed,
   output logic            o_synced,
   output logic            o_at_open_point,
   output logic            o_attempts_done
);
   logic [5:0] run_q;
   logic [5:0] syn_q;
   logic [5:0] rmp_q;
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         run_q <= 6'h00;
         syn_q <= 6'h00;
         rmp_q <= 6'h00;
         o_running <= 1'b0;
         o_gen_closed <= 1'b0;
         o_grid_closed <= 1'b0;
      end else begin
         run_q <= (i_start_seq || i_stop_seq) ? run_q + 6'h01 : 6'h00;
         syn_q <= i_sync_active ? syn_q + 6'h01 : 6'h00;
         rmp_q <= i_ramp_down ? rmp_q + 6'h01 : 6'h00;
         // Cranking or coasting needs the command held for i_dly+1 cycles
         if (run_q == {2'b00, i_dly})
            o_running <= i_start_seq;
         if (i_gen_close || i_gen_open)
            o_gen_closed <= i_gen_close;
         if (i_grid_close || i_grid_open)
            o_grid_closed <= i_grid_close;
      end
   end
   assign o_synced = syn_q > {2'b00, i_dly};
   assign o_at_open_point = rmp_q > {2'b00, i_dly};
   // Engine always fires, so the attempt limit is never reached
   assign o_attempts_done = 1'b0;
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench import genset_pkg::*;;
   logic        i_mclk = 1'b0;
   logic        i_reset = 1'b1;
   logic [3:0]  i_addr = 4'h0;
   logic [15:0] i_wdata = 16'h0000;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   logic [6:0]  i_panel_cmd = 7'h00;
   logic [6:0]  i_dig_cmd = 7'h00;
   logic [3:0]  i_trim_pins = 4'h0;
   logic [3:0]  dly = 4'h3;
   logic [15:0] regm [3] = '{16'h0001, 16'h0100, 16'h0000};
   int          mismatches = 0;
   int          cmp_count = 0;
   wire  [15:0] o_rdata;
   wire  [6:0]  o_load_setp;
   wire  [3:0]  o_trim;
   wire  [2:0]  o_mode;
   wire         o_start_seq, o_stop_seq, o_gen_close, o_gen_open, o_grid_close, o_grid_open;
   wire         o_sync_active, o_ramp_down, o_regulate, o_load_setp_en;
   wire         i_running, i_gen_closed, i_grid_closed, i_synced, i_at_open_point, i_attempts_done;
   wire  [9:0]  obs = {o_mode == MODE_AUTO, o_ramp_down, o_load_setp_en, o_grid_open, o_gen_open,
                       o_grid_close, o_gen_close, o_sync_active, o_stop_seq, o_start_seq};
   genset_sequencer #(.COOL_CYC(32'h14), .EXT_STOP_CYC(32'h14), .TENTH_CYC(32'hA)) dut (
      .i_mclk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_panel_cmd, .i_dig_cmd, .i_trim_pins,
      .i_running, .i_gen_closed, .i_grid_closed, .i_synced, .i_at_open_point, .i_attempts_done,
      .o_start_seq, .o_stop_seq, .o_gen_close, .o_gen_open, .o_grid_close, .o_grid_open, .o_sync_active,
      .o_ramp_down, .o_regulate, .o_load_setp_en, .o_load_setp, .o_trim, .o_mode);
   genset_plant plant (.i_mclk, .i_reset, .i_dly(dly), .i_start_seq(o_start_seq), .i_stop_seq(o_stop_seq),
      .i_gen_close(o_gen_close), .i_gen_open(o_gen_open), .i_grid_close(o_grid_close),
      .i_grid_open(o_grid_open), .i_sync_active(o_sync_active), .i_ramp_down(o_ramp_down),
      .o_running(i_running), .o_gen_closed(i_gen_closed), .o_grid_closed(i_grid_closed),
      .o_synced(i_synced), .o_at_open_point(i_at_open_point), .o_attempts_done(i_attempts_done));
   initial begin
      forever #12.5 i_mclk = ~i_mclk;
   end
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk({15'h0000, got}, {15'h0000, exp});
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_mclk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      // Timer clamps at 999.0 minutes
      if (a < 4'h3)
         regm[a[1:0]] = (a == 4'h2 && d > 16'h2706) ? 16'h2706 : d;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge i_mclk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 chk(o_rdata, exp);
   endtask
   task automatic cmd(input int b);
      @(posedge i_mclk);
      i_panel_cmd <= 7'h01 << b;
      @(posedge i_mclk);
      i_panel_cmd <= 7'h00;
   endtask
   // Waits for obs[k] to reach v, sampling just after each edge so one-cycle pulses are seen
   task automatic wt(input int k, input logic v, input int n);
      int c = 0;
      #1;
      while (obs[k] !== v && c < n) begin
         @(posedge i_mclk);
         #1 c++;
      end
      chk1(obs[k], v);
      if (obs[k] !== v)
         end_sim();
   endtask
   initial begin
      logic [6:0] sp;
      void'($urandom(32'h6d1a05ef));
      sp = 7'(1 + $urandom % 100);
      dly <= 4'(2 + $urandom % 5);
      repeat (2) @(posedge i_mclk);
      i_reset <= 1'b0;
      for (int a = 0; a < 3; a++)
         rd(4'(a), regm[a]);
      rd(4'h4, 16'h0000);
      rd(4'hF, 16'h0000);
      wr(4'h2, 16'hFFFF);
      rd(4'h2, regm[2]);
      repeat (20) @(posedge i_mclk);
      #1 chk1(o_start_seq, 1'b0);
      cmd(0);
      wt(0, 1'b1, 8);
      wt(0, 1'b0, 40);
      repeat (4) @(posedge i_mclk);
      #1 chk1(o_regulate, 1'b1);
      for (int k = 0; k < 4; k++) begin
         @(posedge i_mclk);
         i_trim_pins <= 4'h1 << k;
         repeat (8) @(posedge i_mclk);
         #1 chk({12'h000, o_trim}, {12'h000, 4'h1 << k});
         chk1(o_regulate, 1'b0);
         @(posedge i_mclk);
         i_trim_pins <= 4'h0;
         repeat (8) @(posedge i_mclk);
         #1 chk({12'h000, o_trim}, 16'h0000);
      end
      wr(4'h0, 16'h0011);
      cmd(2);
      wt(3, 1'b1, 4);
      repeat (6) @(posedge i_mclk);
      #1 chk1(o_regulate, 1'b0);
      wr(4'h0, 16'h0001);
      wr(4'h4, 16'h0010);
      wt(2, 1'b1, 8);
      wt(4, 1'b1, 30);
      // The generator open command is only taken once the sequence is back in run
      wt(2, 1'b0, 8);
      cmd(3);
      wt(8, 1'b1, 8);
      wt(5, 1'b1, 30);
      cmd(5);
      wt(6, 1'b1, 4);
      wt(8, 1'b0, 8);
      cmd(1);
      repeat (5) @(posedge i_mclk);
      #1 chk1(o_stop_seq, 1'b0);
      cmd(1);
      wt(1, 1'b1, 6);
      wt(1, 1'b0, 80);
      chk1(i_running, 1'b0);
      wr(4'h1, 16'h0101);
      for (int i = 0; i < 2; i++) begin
         wr(4'h0, i ? 16'h0029 : 16'h0001);
         @(posedge i_mclk);
         i_dig_cmd <= 7'h40;
         repeat (20) @(posedge i_mclk);
         #1 chk1(o_start_seq, 1'b0);
         @(posedge i_mclk);
         i_dig_cmd <= 7'h00;
      end
      wr(4'h1, {1'b0, sp, 4'h0, RET_AUTO, TEST_SIMPLE});
      wr(4'h2, 16'h0001);
      wr(4'h0, 16'h0001);
      cmd(6);
      wt(0, 1'b1, 8);
      wt(9, 1'b1, 400);
      chk1(i_gen_closed, 1'b0);
      wr(4'h0, 16'h0021);
      cmd(4);
      wt(4, 1'b1, 4);
      wr(4'h1, {1'b0, sp, 4'h0, RET_NONE, TEST_LOAD});
      wr(4'h2, 16'h0000);
      cmd(6);
      wt(7, 1'b1, 300);
      chk({9'h000, o_load_setp}, {9'h000, sp});
      repeat (200) @(posedge i_mclk);
      #1 chk1(o_load_setp_en, 1'b1);
      wr(4'h0, 16'h0004);
      cmd(0);
      repeat (20) @(posedge i_mclk);
      #1 chk1(o_start_seq, 1'b0);
      end_sim();
   end
   initial begin
      repeat (100000) @(posedge i_mclk);
      mismatches++;
      end_sim();
   end
endmodule
`default_nettype wire
